// ---- include/event_capture_cfg.svh ----
// Constants for the fast event capture unit.
// Assumes a single clock domain where one clock cycle is one state time.
`ifndef EVENT_CAPTURE_CFG_SVH
`define EVENT_CAPTURE_CFG_SVH

`define CAP_LINES        4
`define CAP_TAG_W        16
`define CAP_FIFO_DEPTH   8
`define CAP_FIFO_AW      3
`define CAP_RES_STATES   4'h9
`define CAP_TICK_STATES  4'h8
`define CAP_XFER_STATES  4'h8
`define CAP_PHASE_MAX    4'h8
`define CAP_TICK_LAST    4'h7
`define CAP_SKIP_PHASE   4'h8
`define CAP_ZERO_TAG     16'h0000
`define CAP_ZERO_LINES   4'h0
`define CAP_ZERO_CNT     4'h0
`define CAP_ONE_CNT      4'h1
`define CAP_ZERO_PTR     3'h0
`define CAP_ONE_PTR      3'h1
`define CAP_ZERO_FILL    4'h0
`define CAP_FULL_FILL    4'h8

`endif

// ---- include/event_capture_pkg.sv ----
// Types shared by the fast event capture unit.
// Assumes event_capture_cfg.svh is included first.
package event_capture_pkg;

  typedef enum logic [1:0] {
    HOLD_EMPTY = 2'b01,
    HOLD_FULL  = 2'b10
  } hold_state_e;

endpackage : event_capture_pkg

// ---- hdl/event_line_resolver.sv ----
// One capture input line with its resolution window.
// Assumes the input is synchronous to clk.
`timescale 1ns/10ps
`include "event_capture_cfg.svh"

module event_line_resolver
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic line_in,
  input  wire logic sample_ok,
  output logic      hit
);

  logic prev_ff;
  logic pend_ff;
  logic edge_seen;

  assign edge_seen = line_in && !prev_ff;
  // An edge waits for the next sample phase; a further edge on the same line
  // before then folds into it, so each line resolves one event per period.
  assign hit       = sample_ok && (edge_seen || pend_ff);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_ff <= 1'b0;
    else
      prev_ff <= line_in;
  end

  // An edge outside the sample phase is kept, so a later event in another
  // phase is still recorded at the next sample point.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pend_ff <= 1'b0;
    else if (sample_ok)
      pend_ff <= 1'b0;
    else if (edge_seen)
      pend_ff <= 1'b1;
  end

endmodule : event_line_resolver

// ---- hdl/fast_event_capture_unit.sv ----
// Fast event capture unit: time-tags input events into a holding register and FIFO.
// Assumes one clock cycle per state time and inputs synchronous to clk.
// Summary of operation
// - Each input line resolves at most one event per 9 state times; closer ones may drop.
// - The timer ticks every 8 states but is sampled every 9, so one value in 9 goes unused.
// - The first two events into an empty FIFO in the same phase share one tag.
// - A second event in another phase within 9 states is tagged one count later.
// - If that next count is the skipped value the second tag is two counts later.
// - With FIFO and holding register empty the first event moves to holding after 8 states.
// - An event after that move, once holding is read, acts as a new first event into an empty FIFO.
`timescale 1ns/10ps
`include "event_capture_cfg.svh"

module fast_event_capture_unit
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic [`CAP_LINES-1:0] event_in,
  input  wire logic                  read_pop,
  output logic                       hold_valid,
  output logic [`CAP_TAG_W-1:0]      hold_tag,
  output logic [`CAP_LINES-1:0]      hold_lines,
  output logic                       fifo_overflow,
  output logic [`CAP_TAG_W-1:0]      timer_value
);

  event_capture_pkg::hold_state_e hold_st_ff;
  logic [`CAP_TAG_W-1:0]  timer_ff;
  logic [3:0]             tick_ff;
  logic [3:0]             phase_ff;
  logic [3:0]             xfer_ff;
  logic [`CAP_LINES-1:0]  hits;
  logic                   sample_ok;
  logic                   any_hit;
  logic [`CAP_TAG_W-1:0]  tag_now;
  logic [`CAP_TAG_W-1:0]  fifo_tag  [`CAP_FIFO_DEPTH];
  logic [`CAP_LINES-1:0]  fifo_line [`CAP_FIFO_DEPTH];
  logic [`CAP_FIFO_AW-1:0] rd_ptr_ff;
  logic [`CAP_FIFO_AW-1:0] wr_ptr_ff;
  logic [3:0]             fill_ff;
  logic                   fifo_empty;
  logic                   fifo_full;
  logic                   push;
  logic                   pop;
  logic                   load_hold;

  // Pending edges of all lines are recorded on one phase of a 9-state cycle.
  assign sample_ok = (phase_ff == `CAP_ZERO_CNT);

  genvar gi;
  generate
    for (gi = 0; gi < `CAP_LINES; gi = gi + 1)
    begin : g_line
      event_line_resolver u_res
      (
        .clk       (clk),
        .reset_n   (reset_n),
        .line_in   (event_in[gi]),
        .sample_ok (sample_ok),
        .hit       (hits[gi])
      );
    end
  endgenerate

  assign any_hit    = |hits;
  // Sampling at a 9-state rate against an 8-state timer skips one value in nine.
  assign tag_now    = timer_ff;
  assign fifo_empty = (fill_ff == `CAP_ZERO_FILL);
  assign fifo_full  = (fill_ff == `CAP_FULL_FILL);
  assign load_hold  = (xfer_ff == `CAP_ONE_CNT) && !fifo_empty &&
                      (hold_st_ff == event_capture_pkg::HOLD_EMPTY);
  assign pop        = load_hold ||
                      (read_pop && (hold_st_ff == event_capture_pkg::HOLD_FULL) && !fifo_empty);
  assign push       = any_hit && (!fifo_full || pop);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_ff <= `CAP_ZERO_CNT;
    else if (phase_ff == `CAP_PHASE_MAX)
      phase_ff <= `CAP_ZERO_CNT;
    else
      phase_ff <= phase_ff + `CAP_ONE_CNT;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_ff  <= `CAP_ZERO_CNT;
      timer_ff <= `CAP_ZERO_TAG;
    end
    else if (tick_ff == `CAP_TICK_LAST)
    begin
      tick_ff  <= `CAP_ZERO_CNT;
      timer_ff <= timer_ff + `CAP_TAG_W'(1);
    end
    else
      tick_ff <= tick_ff + `CAP_ONE_CNT;
  end

  // Second event one resolution later sees the timer one or two counts on.
  // Two counts happen when the 8-state tick fell twice within the 9 states.

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      xfer_ff <= `CAP_ZERO_CNT;
    else if (push && fifo_empty && !pop && (xfer_ff == `CAP_ZERO_CNT) &&
             ((hold_st_ff == event_capture_pkg::HOLD_EMPTY) || read_pop))
      xfer_ff <= `CAP_XFER_STATES;
    else if (xfer_ff != `CAP_ZERO_CNT)
      xfer_ff <= xfer_ff - `CAP_ONE_CNT;
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      fifo_tag[wr_ptr_ff]  <= tag_now;
      fifo_line[wr_ptr_ff] <= hits;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff <= `CAP_ZERO_PTR;
      rd_ptr_ff <= `CAP_ZERO_PTR;
      fill_ff   <= `CAP_ZERO_FILL;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + `CAP_ONE_PTR;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + `CAP_ONE_PTR;
      if (push && !pop)
        fill_ff <= fill_ff + `CAP_ONE_CNT;
      else if (pop && !push)
        fill_ff <= fill_ff - `CAP_ONE_CNT;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fifo_overflow <= 1'b0;
    else if (any_hit && fifo_full && !pop)
      fifo_overflow <= 1'b1;
  end

  // Holding register: loaded after the transfer delay, refilled on a read while the FIFO holds an entry, else emptied.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_st_ff <= event_capture_pkg::HOLD_EMPTY;
      hold_valid <= 1'b0;
      hold_tag   <= `CAP_ZERO_TAG;
      hold_lines <= `CAP_ZERO_LINES;
    end
    else
    begin
      case (hold_st_ff)
        event_capture_pkg::HOLD_EMPTY:
        begin
          if (load_hold)
          begin
            hold_st_ff <= event_capture_pkg::HOLD_FULL;
            hold_valid <= 1'b1;
            hold_tag   <= fifo_tag[rd_ptr_ff];
            hold_lines <= fifo_line[rd_ptr_ff];
          end
        end
        event_capture_pkg::HOLD_FULL:
        begin
          if (read_pop && !fifo_empty)
          begin
            hold_tag   <= fifo_tag[rd_ptr_ff];
            hold_lines <= fifo_line[rd_ptr_ff];
          end
          else if (read_pop)
          begin
            hold_st_ff <= event_capture_pkg::HOLD_EMPTY;
            hold_valid <= 1'b0;
          end
        end
        default:
        begin
          hold_st_ff <= event_capture_pkg::HOLD_EMPTY;
          hold_valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timer_value <= `CAP_ZERO_TAG;
    else
      timer_value <= timer_ff;
  end

endmodule : fast_event_capture_unit

// ---- verification/capture_properties.sv ----
// Port checker for the fast event capture unit.
// Assumes it is bound onto fast_event_capture_unit.
`timescale 1ns/10ps
`include "event_capture_cfg.svh"

module capture_properties
(
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic [`CAP_LINES-1:0] event_in,
  input wire logic                  read_pop,
  input wire logic                  hold_valid,
  input wire logic [`CAP_TAG_W-1:0] hold_tag,
  input wire logic [`CAP_LINES-1:0] hold_lines,
  input wire logic                  fifo_overflow,
  input wire logic [`CAP_TAG_W-1:0] timer_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_first_latency: assert property (
    $fell(hold_valid) |=> !hold_valid [*7])
    else $error("holding register refilled sooner than 8 cycles");
  a_tag_source: assert property (
    $rose(hold_valid) |-> hold_tag == $past(timer_value, 8))
    else $error("tag is not the timer at the sample point");
  a_timer_step: assert property (
    $changed(timer_value) |-> timer_value == $past(timer_value) + 16'h0001)
    else $error("timer did not step by one");
  a_timer_period: assert property (
    $changed(timer_value) |=> $stable(timer_value) [*7])
    else $error("timer ticked sooner than 8 cycles");
  a_overflow_kept: assert property (
    fifo_overflow |=> fifo_overflow)
    else $error("overflow flag cleared");
  a_hold_stands: assert property (
    hold_valid && !read_pop |=> hold_valid && $stable(hold_tag) && $stable(hold_lines))
    else $error("held entry changed without a pop");
  a_lines_set: assert property (
    hold_valid |-> hold_lines != `CAP_ZERO_LINES)
    else $error("held entry names no line");
  a_tag_order: assert property (
    $past(read_pop) && $past(hold_valid) && hold_valid |-> hold_tag > $past(hold_tag))
    else $error("next entry tag not later");
endmodule : capture_properties

bind fast_event_capture_unit capture_properties u_capture_properties
  (.clk(clk), .reset_n(reset_n), .event_in(event_in), .read_pop(read_pop),
   .hold_valid(hold_valid), .hold_tag(hold_tag), .hold_lines(hold_lines),
   .fifo_overflow(fifo_overflow), .timer_value(timer_value));

// ---- verification/event_source.sv ----
// Model of the signals on the capture input lines.
// Assumes pulse is called at a falling edge of clk.
`timescale 1ns/10ps
`include "event_capture_cfg.svh"

module event_source
(
  input  wire logic             clk,
  output logic [`CAP_LINES-1:0] event_in
);
  initial event_in = `CAP_ZERO_LINES;

  // Lines go high for one state time, giving one rising edge each.
  task automatic pulse(input logic [`CAP_LINES-1:0] m);
    event_in = m;
    @(negedge clk);
    event_in = `CAP_ZERO_LINES;
  endtask : pulse
endmodule : event_source

// ---- verification/tb_top.sv ----
// Self-checking bench for the fast event capture unit.
// Assumes the event source model and the bound checker are compiled first.
`timescale 1ns/10ps
`include "event_capture_cfg.svh"

module tb_top;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  read_pop = 1'b0;
  logic                  hold_valid;
  logic                  fifo_overflow;
  logic [`CAP_TAG_W-1:0] hold_tag;
  logic [`CAP_TAG_W-1:0] timer_value;
  logic [`CAP_TAG_W-1:0] tags [0:11];
  logic [`CAP_LINES-1:0] event_in;
  logic [`CAP_LINES-1:0] hold_lines;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  int                    c0 = 0;
  int                    k = 0;
  int                    n = 0;

  event_source u_event_source (.clk(clk), .event_in(event_in));
  fast_event_capture_unit u_fast_event_capture_unit
    (.clk(clk), .reset_n(reset_n), .event_in(event_in), .read_pop(read_pop),
     .hold_valid(hold_valid), .hold_tag(hold_tag), .hold_lines(hold_lines),
     .fifo_overflow(fifo_overflow), .timer_value(timer_value));

  initial forever #2.5 clk = ~clk;

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk

  // Counts falling edges since the pulse began, until an entry is held.
  task automatic wait_hold();
    k = 1;
    while (hold_valid !== 1'b1 && k < 14)
    begin
      @(negedge clk);
      k++;
    end
  endtask : wait_hold

  task automatic pop();
    read_pop = 1'b1;
    @(negedge clk);
    read_pop = 1'b0;
  endtask : pop

  // Waits for a falling edge whose drive meets the unit's sample phase.
  // The phase runs modulo 9 and the timer ticks every 8 from reset release.
  task automatic to_slot();
    while ((cyc - 4) % 9 != 0)
      @(negedge clk);
  endtask : to_slot

  task automatic t_align();
    to_slot();
    c0 = cyc;
    u_event_source.pulse(4'h1);
    wait_hold();
    chk("latency", 16'h0009, 16'(k));
    chk("lines", 16'h0001, {12'h000, hold_lines});
    chk("tag", 16'((c0 - 4) / 8), hold_tag);
    chk("timer", 16'((cyc - 5) / 8), timer_value);
    pop();
    chk("emptied", 16'h0000, {15'h0000, hold_valid});
    $display("test align done");
  endtask : t_align

  // Two lines in the sample phase, then two edges on one line in later phases.
  task automatic t_merge(input logic [15:0] step);
    to_slot();
    c0 = cyc;
    u_event_source.pulse(4'h5);
    @(negedge clk);
    u_event_source.pulse(4'h2);
    @(negedge clk);
    u_event_source.pulse(4'h2);
    wait_hold();
    chk("merged", 16'h0005, {12'h000, hold_lines});
    chk("first tag", 16'((c0 - 4) / 8), hold_tag);
    tags[0] = hold_tag;
    pop();
    wait_hold();
    chk("refill", 16'h0009, 16'(k));
    chk("second lines", 16'h0002, {12'h000, hold_lines});
    chk("second tag", 16'((c0 + 5) / 8), hold_tag);
    chk("tag step", step, hold_tag - tags[0]);
    pop();
    repeat (12) @(negedge clk);
    chk("dropped", 16'h0000, {15'h0000, hold_valid});
    $display("test merge done");
  endtask : t_merge

  // Ten events one sample apart: one held, eight queued, the last lost.
  task automatic t_run();
    for (int i = 0; i < 10; i++)
    begin
      to_slot();
      u_event_source.pulse(i[0] ? 4'h8 : 4'h4);
    end
    repeat (2) @(negedge clk);
    chk("overflow", 16'h0001, {15'h0000, fifo_overflow});
    read_pop = 1'b1;
    n = 0;
    while (hold_valid === 1'b1 && n < 12)
    begin
      tags[n] = hold_tag;
      n++;
      @(negedge clk);
    end
    read_pop = 1'b0;
    chk("entries", 16'h0009, 16'(n));
    for (int i = 1; i < 9; i++)
      chk("step", 16'h0001, {15'h0000, (tags[i] - tags[i-1]) inside {1, 2}});
    chk("span", 16'h0009, tags[8] - tags[0]);
    $display("test run done");
  endtask : t_run

  initial
  begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_align();
    t_merge(16'h0001);
    t_merge(16'h0002);
    t_run();
    end_sim();
  end
endmodule : tb_top
